/* File: fevs_pkg.sv */
package fevs_pkg;
  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_DIVIDER = 8'h00;
  localparam logic [7:0] ADDR_STATUS  = 8'h04;
  localparam logic [7:0] ADDR_INDEX   = 8'h08;
  localparam logic [7:0] ADDR_WORD0   = 8'h0C;
  localparam logic [7:0] ADDR_WORD1   = 8'h10;
  localparam logic [7:0] ADDR_MARGIN  = 8'h14;
  // status register fields
  localparam int ST_COMPLETE   = 7;
  localparam int ST_ACCESS_ERR = 5;
  localparam int ST_PROT_VIOL  = 4;
  localparam int ST_MG1    = 1;
  localparam int ST_MG0    = 0;
  localparam int DIV_DONE  = 7;
  // ---------------------------------------------------------------
  // command codes
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_EV_ALL   = 8'h01;
  localparam logic [7:0] CMD_EV_BLOCK = 8'h02;
  localparam logic [7:0] CMD_EV_SECT  = 8'h03;
  localparam logic [7:0] CMD_RD_ONCE  = 8'h04;
  localparam logic [7:0] CMD_PROG_PF  = 8'h06;
  localparam logic [7:0] CMD_PROG_ONC = 8'h07;
  localparam logic [7:0] CMD_ERS_ALL  = 8'h08;
  localparam logic [7:0] CMD_ERS_BLK  = 8'h09;
  localparam logic [7:0] CMD_ERS_SECT = 8'h0A;
  localparam logic [7:0] CMD_UNSECURE = 8'h0B;
  localparam logic [7:0] CMD_BACKDOOR = 8'h0C;
  localparam logic [7:0] CMD_USR_MRG  = 8'h0D;
  localparam logic [7:0] CMD_FLD_MRG  = 8'h0E;
  localparam logic [7:0] CMD_EV_EESEC = 8'h10;
  localparam logic [7:0] CMD_PROG_EE  = 8'h11;
  localparam logic [7:0] CMD_ERS_EESC = 8'h12;
  localparam logic [7:0] CMD_PROT_OVR = 8'h13;
  localparam logic [2:0] IDX_EV_ALL   = 3'h0;
  localparam logic [2:0] IDX_EV_BLOCK = 3'h1;
  // block identity by global address bits [23:16]
  localparam logic [7:0] PF_BLOCK_HI  = 8'hFF;
  localparam logic [7:0] EE_BLOCK_HI  = 8'h10;
  localparam logic [15:0] BLOCK_LO    = 16'h0000;
  localparam logic [15:0] EE_BLOCK_LO = 16'h0000;
  localparam int SETUP_CYCLES = 4;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    FEVS_IDLE  = 2'b00,
    FEVS_SETUP = 2'b01,
    FEVS_RUN   = 2'b11
  } fevs_state_t;
  typedef enum logic [1:0] {
    FEVS_OP_NONE = 2'b00,
    FEVS_OP_PROG = 2'b01,
    FEVS_OP_SECT = 2'b10,
    FEVS_OP_MASS = 2'b11
  } fevs_op_t;
endpackage

/* File: fevs_top.sv */
module fevs_top #(
  parameter int BLOCK_WORDS = 64
) (
  input  wire logic        SYS_CLK,
  input  wire logic        RST_B,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        PF_RD_REQ,
  input  wire logic        EE_RD_REQ,
  output logic             PF_RD_GRANT,
  output logic             EE_RD_GRANT,
  output logic             RD_DATA_VALID,
  output logic             ILLEGAL_ACCESS,
  output logic             ARR_RD_EN,
  output logic             ARR_SEL_EE,
  output logic [15:0]      ARR_ADDR,
  input  wire logic        ARR_BLANK,
  input  wire logic        ARR_ERR_CORR,
  input  wire logic        ARR_ERR_UNCORR,
  output logic             ARR_BUSY
);
  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0]  divider;
  logic        div_done;
  logic [2:0]  word_index;
  logic [15:0] word0;
  logic [15:0] word1;
  logic [1:0]  margin;
  logic        command_complete_flag;
  logic        access_error_flag;
  logic        protection_violation_flag;
  logic        mg1;
  logic        mg0;
  fevs_pkg::fevs_state_t state;
  fevs_pkg::fevs_op_t    op_kind;
  logic        op_on_ee;
  logic        op_all;
  logic [2:0]  setup_cnt;
  logic [15:0] addr_cnt;
  logic        sweep_ee;

  logic wr_acc;
  logic rd_acc;
  logic launch;
  logic [7:0] cmd;
  logic cmd_valid;
  logic cmd_pe;
  logic bad_launch;
  logic addr_ok;
  logic blk_ee;
  logic last_word;

  assign PREADY  = 1'b1;
  assign PSLVERR = 1'b0;
  assign wr_acc  = PSEL && PENABLE && PWRITE;
  assign rd_acc  = PSEL && PENABLE && !PWRITE;
  assign cmd     = word0[15:8];
  // host clears the complete flag (write 1) to launch
  assign launch  = wr_acc && PADDR == fevs_pkg::ADDR_STATUS
                   && PWDATA[fevs_pkg::ST_COMPLETE] && command_complete_flag;

  always_comb begin
    unique case (cmd)
      fevs_pkg::CMD_EV_ALL, fevs_pkg::CMD_EV_BLOCK, fevs_pkg::CMD_EV_SECT,
      fevs_pkg::CMD_RD_ONCE, fevs_pkg::CMD_PROG_PF, fevs_pkg::CMD_PROG_ONC,
      fevs_pkg::CMD_ERS_ALL, fevs_pkg::CMD_ERS_BLK, fevs_pkg::CMD_ERS_SECT,
      fevs_pkg::CMD_UNSECURE, fevs_pkg::CMD_BACKDOOR,
      fevs_pkg::CMD_USR_MRG, fevs_pkg::CMD_FLD_MRG,
      fevs_pkg::CMD_EV_EESEC, fevs_pkg::CMD_PROG_EE,
      fevs_pkg::CMD_ERS_EESC, fevs_pkg::CMD_PROT_OVR: cmd_valid = 1'b1;
      default: cmd_valid = 1'b0;
    endcase
  end

  // commands that program or erase need the divider first
  assign cmd_pe = cmd == fevs_pkg::CMD_PROG_PF
               || cmd == fevs_pkg::CMD_PROG_ONC
               || cmd == fevs_pkg::CMD_ERS_ALL
               || cmd == fevs_pkg::CMD_ERS_BLK
               || cmd == fevs_pkg::CMD_ERS_SECT
               || cmd == fevs_pkg::CMD_UNSECURE
               || cmd == fevs_pkg::CMD_PROG_EE
               || cmd == fevs_pkg::CMD_ERS_EESC;
  assign blk_ee  = word0[7:0] == fevs_pkg::EE_BLOCK_HI
                && word1 == fevs_pkg::EE_BLOCK_LO;
  assign addr_ok = blk_ee || (word0[7:0] == fevs_pkg::PF_BLOCK_HI
                && word1 == fevs_pkg::BLOCK_LO);

  always_comb begin
    bad_launch = 1'b0;
    if (!cmd_valid)
      bad_launch = 1'b1;
    else if (cmd_pe && !div_done)
      bad_launch = 1'b1;
    else if (cmd == fevs_pkg::CMD_EV_ALL
             && word_index != fevs_pkg::IDX_EV_ALL)
      bad_launch = 1'b1;
    else if (cmd == fevs_pkg::CMD_EV_BLOCK
             && word_index != fevs_pkg::IDX_EV_BLOCK)
      bad_launch = 1'b1;
    else if (cmd == fevs_pkg::CMD_EV_BLOCK && !addr_ok)
      bad_launch = 1'b1;
  end

  // ---------------------------------------------------------------
  // software registers
  // ---------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      divider    <= 8'h00;
      div_done   <= 1'b0;
      word_index <= 3'h0;
      word0      <= 16'h0000;
      word1      <= 16'h0000;
      margin     <= 2'h0;
    end else if (wr_acc && command_complete_flag) begin
      unique case (PADDR)
        fevs_pkg::ADDR_DIVIDER: begin
          divider  <= PWDATA[7:0];
          div_done <= 1'b1;
        end
        fevs_pkg::ADDR_INDEX:  word_index <= PWDATA[2:0];
        fevs_pkg::ADDR_WORD0:  word0      <= PWDATA[15:0];
        fevs_pkg::ADDR_WORD1:  word1      <= PWDATA[15:0];
        fevs_pkg::ADDR_MARGIN: margin     <= PWDATA[1:0];
        default: ;
      endcase
    end
  end

  always_comb begin
    PRDATA = 32'h0000_0000;
    unique case (PADDR)
      fevs_pkg::ADDR_DIVIDER: PRDATA = {24'h000000, divider};
      fevs_pkg::ADDR_STATUS: begin
        PRDATA[fevs_pkg::ST_COMPLETE]   = command_complete_flag;
        PRDATA[fevs_pkg::ST_ACCESS_ERR] = access_error_flag;
        PRDATA[fevs_pkg::ST_PROT_VIOL]  = protection_violation_flag;
        PRDATA[fevs_pkg::ST_MG1]    = mg1;
        PRDATA[fevs_pkg::ST_MG0]    = mg0;
      end
      fevs_pkg::ADDR_INDEX:  PRDATA = {29'h0, word_index};
      fevs_pkg::ADDR_WORD0:  PRDATA = {16'h0000, word0};
      fevs_pkg::ADDR_WORD1:  PRDATA = {16'h0000, word1};
      fevs_pkg::ADDR_MARGIN: PRDATA = {30'h0, margin};
      default: PRDATA = 32'h0000_0000;
    endcase
  end

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  assign last_word = addr_cnt == 16'(BLOCK_WORDS - 1);
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state     <= fevs_pkg::FEVS_IDLE;
      command_complete_flag <= 1'b1;
      op_kind   <= fevs_pkg::FEVS_OP_NONE;
      op_on_ee  <= 1'b0;
      op_all    <= 1'b0;
      setup_cnt <= 3'h0;
      addr_cnt  <= 16'h0000;
      sweep_ee  <= 1'b0;
    end else begin
      unique case (state)
        fevs_pkg::FEVS_IDLE: begin
          if (launch && !bad_launch && !access_error_flag
              && !protection_violation_flag) begin
            command_complete_flag <= 1'b0;
            state     <= fevs_pkg::FEVS_SETUP;
            setup_cnt <= 3'h0;
            addr_cnt  <= 16'h0000;
            op_all    <= cmd == fevs_pkg::CMD_EV_ALL;
            op_on_ee  <= cmd == fevs_pkg::CMD_PROG_EE
                      || cmd == fevs_pkg::CMD_ERS_EESC
                      || cmd == fevs_pkg::CMD_EV_EESEC
                      || (cmd == fevs_pkg::CMD_EV_BLOCK && blk_ee);
            sweep_ee  <= cmd == fevs_pkg::CMD_EV_BLOCK && blk_ee;
            if (cmd == fevs_pkg::CMD_ERS_ALL
                || cmd == fevs_pkg::CMD_ERS_BLK)
              op_kind <= fevs_pkg::FEVS_OP_MASS;
            else if (cmd == fevs_pkg::CMD_ERS_SECT
                     || cmd == fevs_pkg::CMD_ERS_EESC)
              op_kind <= fevs_pkg::FEVS_OP_SECT;
            else if (cmd_pe)
              op_kind <= fevs_pkg::FEVS_OP_PROG;
            else
              op_kind <= fevs_pkg::FEVS_OP_NONE;
          end
        end
        fevs_pkg::FEVS_SETUP: begin
          // reads still valid here, array untouched yet
          setup_cnt <= setup_cnt + 3'h1;
          if (setup_cnt == 3'(fevs_pkg::SETUP_CYCLES - 1))
            state <= fevs_pkg::FEVS_RUN;
        end
        fevs_pkg::FEVS_RUN: begin
          addr_cnt <= addr_cnt + 16'h0001;
          if (last_word) begin
            addr_cnt <= 16'h0000;
            if (op_all && !sweep_ee) begin
              sweep_ee <= 1'b1;
            end else begin
              command_complete_flag <= 1'b1;
              state <= fevs_pkg::FEVS_IDLE;
            end
          end
        end
        default: state <= fevs_pkg::FEVS_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // status flags
  // ---------------------------------------------------------------
  logic verifying;
  assign verifying = state == fevs_pkg::FEVS_RUN
                  && op_kind == fevs_pkg::FEVS_OP_NONE;
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      access_error_flag         <= 1'b0;
      protection_violation_flag <= 1'b0;
      mg1    <= 1'b0;
      mg0    <= 1'b0;
    end else begin
      // write-one clears; a new error in the same cycle wins
      if (wr_acc && PADDR == fevs_pkg::ADDR_STATUS) begin
        if (PWDATA[fevs_pkg::ST_ACCESS_ERR]) access_error_flag <= 1'b0;
        if (PWDATA[fevs_pkg::ST_PROT_VIOL]) protection_violation_flag <= 1'b0;
      end
      if (launch && state == fevs_pkg::FEVS_IDLE) begin
        mg1 <= 1'b0;
        mg0 <= 1'b0;
        if (bad_launch)
          access_error_flag <= 1'b1;
      end
      if (verifying) begin
        if (!ARR_BLANK) begin
          mg1 <= 1'b1;
          mg0 <= 1'b1;
        end
        if (ARR_ERR_CORR || ARR_ERR_UNCORR)
          mg1 <= 1'b1;
        if (ARR_ERR_UNCORR)
          mg0 <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // read arbitration and collisions
  // ---------------------------------------------------------------
  logic array_active;
  logic margin_rd;
  logic pf_busy;
  logic ee_busy;
  logic pf_collide;
  logic ee_collide;
  assign array_active = state == fevs_pkg::FEVS_RUN;
  assign margin_rd    = margin != 2'h0;
  // verify sweeps over everything occupy the shared read path
  assign pf_busy = array_active && (!op_on_ee || op_all);
  assign ee_busy = array_active && (op_on_ee || op_all
                || op_kind == fevs_pkg::FEVS_OP_MASS);
  // eeprom program/erase leaves pflash reads free, except margin
  // reads and mass erase which share hardware
  assign pf_collide = PF_RD_REQ && (pf_busy || (array_active
                   && (margin_rd || op_kind == fevs_pkg::FEVS_OP_MASS
                   || op_kind == fevs_pkg::FEVS_OP_NONE)));
  assign ee_collide = EE_RD_REQ && !PF_RD_REQ && ee_busy;

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      PF_RD_GRANT    <= 1'b0;
      EE_RD_GRANT    <= 1'b0;
      RD_DATA_VALID  <= 1'b0;
      ILLEGAL_ACCESS <= 1'b0;
    end else begin
      // one read at a time, pflash first
      PF_RD_GRANT    <= PF_RD_REQ && !pf_collide;
      EE_RD_GRANT    <= EE_RD_REQ && !PF_RD_REQ && !ee_collide;
      RD_DATA_VALID  <= (PF_RD_REQ && !pf_collide)
                     || (EE_RD_REQ && !PF_RD_REQ && !ee_collide);
      ILLEGAL_ACCESS <= pf_collide || ee_collide;
    end
  end

  assign ARR_RD_EN  = verifying;
  assign ARR_SEL_EE = sweep_ee;
  assign ARR_ADDR   = addr_cnt;
  assign ARR_BUSY   = array_active;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_bad_launch;
    launch && bad_launch && state == fevs_pkg::FEVS_IDLE;
  endsequence

  AST_REJECT_FLAG: assert property (
    @(posedge SYS_CLK) disable iff (!rst_n)
    s_bad_launch |=> access_error_flag && command_complete_flag)
    else $error("rejected launch did not flag error");
  AST_DIV_FIRST: assert property (
    @(posedge SYS_CLK) disable iff (!rst_n)
    launch && cmd_pe && !div_done |=> access_error_flag)
    else $error("program without divider not flagged");
  AST_BAD_CODE: assert property (
    @(posedge SYS_CLK) disable iff (!rst_n)
    launch && !cmd_valid && state == fevs_pkg::FEVS_IDLE
    |=> access_error_flag && state == fevs_pkg::FEVS_IDLE)
    else $error("invalid code was not refused");
  AST_ONE_READ: assert property (
    @(posedge SYS_CLK) disable iff (!rst_n)
    !(PF_RD_GRANT && EE_RD_GRANT))
    else $error("two reads granted at once");
  AST_COLLIDE_CYCLE: assert property (
    @(posedge SYS_CLK) disable iff (!rst_n)
    ILLEGAL_ACCESS |-> $past(PF_RD_REQ) || $past(EE_RD_REQ))
    else $error("illegal access without a read");
  AST_SETUP_READ: assert property (
    @(posedge SYS_CLK) disable iff (!rst_n)
    state == fevs_pkg::FEVS_SETUP && PF_RD_REQ |=> RD_DATA_VALID)
    else $error("read refused before array start");
  AST_BLANK_FAIL: assert property (
    @(posedge SYS_CLK) disable iff (!rst_n)
    verifying && !ARR_BLANK |=> mg1 && mg0)
    else $error("blank fail did not set both bits");
  AST_UNCORR: assert property (
    @(posedge SYS_CLK) disable iff (!rst_n)
    verifying && ARR_ERR_UNCORR |=> mg0 && mg1)
    else $error("uncorrectable error not recorded");
  AST_BLOCK_DONE: assert property (
    @(posedge SYS_CLK) disable iff (!rst_n)
    $fell(command_complete_flag) && !op_all
    |-> ##[1:300] command_complete_flag)
    else $error("block verify never completed");
  AST_RWW: assert property (
    @(posedge SYS_CLK) disable iff (!rst_n)
    array_active && op_on_ee && !op_all && !margin_rd
    && op_kind == fevs_pkg::FEVS_OP_PROG && PF_RD_REQ
    |=> PF_RD_GRANT)
    else $error("pflash read blocked by eeprom write");
endmodule

/* File: fevs_array_model.sv */
// ---------------------------------------------------------------
// array model: answers verify reads in the same cycle
// ---------------------------------------------------------------
module fevs_array_model (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        rd_en,
  input  wire logic        sel_ee,
  input  wire logic [15:0] addr,
  input  wire logic [1:0]  mode,
  input  wire logic [15:0] bad_addr,
  output logic             blank,
  output logic             err_corr,
  output logic             err_uncorr,
  output logic [15:0]      pf_reads,
  output logic [15:0]      ee_reads
);
  timeunit 1ns;
  timeprecision 1ps;
  logic tog;
  logic hit;
  // outside a read the answer lines wander, so a stale value never helps
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) tog <= 1'b0;
    else tog <= ~tog;
  end
  assign hit = rd_en && (addr == bad_addr);
  assign blank = rd_en ? !(hit && mode == 2'h1) : tog;
  assign err_corr = rd_en ? (hit && mode == 2'h2) : ~tog;
  assign err_uncorr = rd_en ? (hit && mode == 2'h3) : tog;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pf_reads <= 16'h0000;
      ee_reads <= 16'h0000;
    end else if (rd_en) begin
      if (sel_ee) ee_reads <= ee_reads + 16'h0001;
      else pf_reads <= pf_reads + 16'h0001;
    end
  end
endmodule

/* File: fevs_top_tb.sv */
module fevs_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BW = 8;
  logic sys_clk, rst_b, psel, penable, pwrite, pf_req, ee_req;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, tmp;
  logic pready, pslverr, err_seen, pf_grant, ee_grant, rd_valid, illegal;
  logic arr_en, arr_ee, arr_busy, blank, e_corr, e_unc;
  logic [15:0] arr_addr, bad_addr, pf_reads, ee_reads;
  logic [1:0] mode;
  int failures = 0;
  int checks_done = 0;
  fevs_top #(.BLOCK_WORDS(BW)) dut (
    .SYS_CLK(sys_clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .PF_RD_REQ(pf_req),
    .EE_RD_REQ(ee_req), .PF_RD_GRANT(pf_grant), .EE_RD_GRANT(ee_grant),
    .RD_DATA_VALID(rd_valid), .ILLEGAL_ACCESS(illegal),
    .ARR_RD_EN(arr_en), .ARR_SEL_EE(arr_ee), .ARR_ADDR(arr_addr),
    .ARR_BLANK(blank), .ARR_ERR_CORR(e_corr), .ARR_ERR_UNCORR(e_unc),
    .ARR_BUSY(arr_busy));
  fevs_array_model arr (
    .clk(sys_clk), .rst_b(rst_b), .rd_en(arr_en), .sel_ee(arr_ee),
    .addr(arr_addr), .mode(mode), .bad_addr(bad_addr), .blank(blank),
    .err_corr(e_corr), .err_uncorr(e_unc), .pf_reads(pf_reads),
    .ee_reads(ee_reads));
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic close_out;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    tmp = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      failures++;
      close_out();
    end
    // one idle edge, so a following call never re-drives psel at once
    @(posedge sys_clk);
  endtask
  task automatic st(input logic [31:0] exp);
    apb(1'b0, fevs_pkg::ADDR_STATUS, 32'h0);
    chk(tmp & 32'h000000B3, exp);
  endtask
  task automatic launch(input logic [7:0] code, input logic [7:0] hi,
                        input logic [15:0] lo, input logic [2:0] idx);
    apb(1'b1, fevs_pkg::ADDR_STATUS, 32'h00000030);
    apb(1'b1, fevs_pkg::ADDR_INDEX, {29'h0, idx});
    apb(1'b1, fevs_pkg::ADDR_WORD0, {16'h0, code, hi});
    apb(1'b1, fevs_pkg::ADDR_WORD1, {16'h0, lo});
    apb(1'b1, fevs_pkg::ADDR_STATUS, 32'h00000080);
  endtask
  task automatic wait_flag(input logic busy);
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      #1;
      n++;
    end while (arr_busy !== busy && n < 200);
    @(posedge sys_clk);
    if (n >= 200) begin
      failures++;
      close_out();
    end
  endtask
  // bits: pf grant, ee grant, valid, illegal; then illegal must drop
  task automatic probe(input logic pf, input logic ee,
                       input logic [3:0] exp, input logic [3:0] m);
    pf_req <= pf;
    ee_req <= ee;
    @(posedge sys_clk);
    pf_req <= 1'b0;
    ee_req <= 1'b0;
    #1;
    chk({28'h0, {pf_grant, ee_grant, rd_valid, illegal} & m},
        {28'h0, exp & m});
    @(posedge sys_clk);
    #1;
    chk({31'h0, illegal}, 32'h0);
    @(posedge sys_clk);
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_idle;
    st(32'h80);
    probe(1'b1, 1'b1, 4'b1010, 4'b1111);
    launch(fevs_pkg::CMD_PROG_PF, fevs_pkg::PF_BLOCK_HI, 16'h0, 3'h5);
    st(32'hA0);
    chk({31'h0, arr_busy}, 32'h0);
    $display("test idle and divider done");
  endtask
  task automatic t_reject;
    logic [33:0] tbl [4];
    tbl = '{{8'h05, 8'hFF, 16'h0, 2'h0}, {8'h01, 8'hFF, 16'h0, 2'h1},
            {8'h02, 8'hFF, 16'h0, 2'h0}, {8'h02, 8'h20, 16'h0, 2'h1}};
    for (int i = 0; i < 4; i++) begin
      launch(tbl[i][33:26], tbl[i][25:18], tbl[i][17:2],
             {1'b0, tbl[i][1:0]});
      chk({31'h0, err_seen}, 32'h0);
      st(32'hA0);
    end
    $display("test rejected launches done");
  endtask
  task automatic t_all;
    mode <= 2'h0;
    launch(fevs_pkg::CMD_EV_ALL, 8'h00, 16'h0, fevs_pkg::IDX_EV_ALL);
    probe(1'b1, 1'b0, 4'b0010, 4'b0011);
    wait_flag(1'b1);
    probe(1'b1, 1'b0, 4'b0001, 4'b0001);
    wait_flag(1'b0);
    st(32'h80);
    chk({16'h0, ee_reads}, 32'(BW));
    chk({16'h0, pf_reads}, 32'(BW));
    $display("test verify all done");
  endtask
  task automatic t_block;
    logic [7:0] ex [4];
    ex = '{8'h80, 8'h83, 8'h82, 8'h83};
    for (int i = 0; i < 4; i++) begin
      mode <= i[1:0];
      launch(fevs_pkg::CMD_EV_BLOCK, i[0] ? fevs_pkg::EE_BLOCK_HI :
             fevs_pkg::PF_BLOCK_HI, 16'h0, fevs_pkg::IDX_EV_BLOCK);
      wait_flag(1'b1);
      wait_flag(1'b0);
      st({24'h0, ex[i]});
    end
    mode <= 2'h0;
    $display("test verify block done");
  endtask
  task automatic t_simul;
    launch(fevs_pkg::CMD_PROG_EE, fevs_pkg::EE_BLOCK_HI, 16'h0, 3'h2);
    wait_flag(1'b1);
    probe(1'b1, 1'b0, 4'b0010, 4'b0011);
    probe(1'b0, 1'b1, 4'b0001, 4'b0001);
    wait_flag(1'b0);
    apb(1'b1, fevs_pkg::ADDR_MARGIN, 32'h1);
    launch(fevs_pkg::CMD_PROG_EE, fevs_pkg::EE_BLOCK_HI, 16'h8, 3'h2);
    wait_flag(1'b1);
    probe(1'b1, 1'b0, 4'b0001, 4'b0001);
    wait_flag(1'b0);
    apb(1'b1, fevs_pkg::ADDR_MARGIN, 32'h0);
    launch(fevs_pkg::CMD_ERS_BLK, fevs_pkg::EE_BLOCK_HI, 16'h0, 3'h1);
    wait_flag(1'b1);
    probe(1'b1, 1'b0, 4'b0001, 4'b0001);
    wait_flag(1'b0);
    $display("test simultaneous access done");
  endtask
  // ---------------------------------------------------------------
  // run
  // ---------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (100000) @(posedge sys_clk);
    failures++;
    close_out();
  end
  initial begin
    {rst_b, psel, penable, pwrite, pf_req, ee_req} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    mode = 2'h0;
    bad_addr = 16'h0003;
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge sys_clk);
    t_idle();
    apb(1'b1, fevs_pkg::ADDR_DIVIDER, 32'h00000013);
    t_reject();
    t_all();
    t_block();
    t_simul();
    close_out();
  end
endmodule
